// >>> sit_pkg.sv
package sit_pkg;
  // One clk_i edge is one minor cycle; latencies below count minor cycles, except LOAD_NS, which is in ns
  localparam int MINOR_NS = 20;
  localparam int PC_W = 24;
  localparam int STK_WORDS = 64;
  localparam int SW_WORDS = 8;
  localparam int AHEAD = 16;
  localparam int SLOT_N = 64;
  // Instruction classes, op[6:3]
  localparam logic [3:0] C_INC = 4'h0;
  localparam logic [3:0] C_LOG = 4'h1;
  localparam logic [3:0] C_FADD = 4'h2;
  localparam logic [3:0] C_FMUL = 4'h3;
  localparam logic [3:0] C_FDIV = 4'h4;
  localparam logic [3:0] C_FSQRT = 4'h5;
  localparam logic [3:0] C_LOAD = 4'h6;
  localparam logic [3:0] C_STORE = 4'h7;
  localparam logic [3:0] C_BR = 4'h8;
  localparam logic [3:0] C_CALL = 4'h9;
  localparam logic [3:0] C_VEC = 4'ha;
  // Short-stop and register-file write latencies
  localparam int SS_INC = 1;
  localparam int WR_INC = 4;
  localparam int SS_LOG = 3;
  localparam int WR_LOG = 6;
  localparam int SS_FP = 5;
  localparam int WR_FP = 8;
  localparam int SS_DIV = 54;
  localparam int WR_DIV = 57;
  localparam int SS_SQRT = 53;
  localparam int WR_SQRT = 56;
  localparam int LOAD_NS = 300;
  localparam int WR_LOAD = LOAD_NS / MINOR_NS;
  // Branch and call costs
  localparam logic [5:0] BR_FALL = 6'h08;
  localparam logic [5:0] BR_IN = 6'h09;
  localparam logic [5:0] BR_OUT = 6'h18;
  localparam logic [5:0] CALL_IN = 6'h08;
  localparam logic [5:0] CALL_OUT = 6'h17;
  // Load/store buffer and translation
  localparam int LSQ_N = 6;
  localparam int AS_N = 16;
  localparam int VA_W = 48;
  localparam int PA_W = 22;
  localparam int KEY_W = 8;
  localparam int ENT_W = 80;
  localparam int E_V = 79;
  localparam int E_LG = 78;
  localparam int E_LK = 70;
  localparam int E_PB = 48;
  localparam int SH_512 = 9;
  localparam int SH_2K = 11;
  localparam int SH_8K = 13;
  localparam int SH_LARGE = 16;
  localparam int MEM_WORDS = 4194304;
  localparam int ST_PAIRS = MEM_WORDS / 512 / 2;
  localparam int ST_IDX_W = 12;
endpackage : sit_pkg

// >>> sit_core.sv
// Operation
// [RQ1] One clock edge equals one minor cycle
// [RQ2] Stack of 64 words, mixed instruction lengths
// [RQ3] Keep sixteen words fetched ahead
// [RQ4] Decode, dispatch scalar, forward vector, one/cycle
// [RQ5] Scalar runs beside vector unless referencing memory
// [RQ6] Load each cycle, store every two, pause
// [RQ7] Six-entry circular load/store buffer
// [RQ8] Load data reaches registers after memory return
// [RQ9] Results forwarded to operands while written
// [RQ10] Integer and logical latencies
// [RQ11] Floating add, multiply, divide, root latencies
// [RQ12] Load one issue cycle, store two
// [RQ13] Branch and call costs by target
// [RQ14] Units segmented except divide/root unit
// [RQ15] 256x64 register file, two reads one write
// [RQ16] Sixteen associative registers translate immediately
// [RQ17] Compare all at once, search two per cycle
// [RQ18] Used entries move toward table top
// [RQ19] Small page 512/2048/8192, large 65536
// [RQ20] 48-bit virtual addresses mapped to physical
// [RQ21] Program key checked against page lock
// [RQ22] Space table covers four million words
// [RQ23] On miss search table, install, retry
`timescale 1ns/1ns
`default_nettype none
module sit_core (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic fetch_req_o,
  output logic [sit_pkg::PC_W-5:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire logic [511:0] fetch_data_i,
  output logic vec_valid_o,
  output logic [63:0] vec_instr_o,
  input wire logic vec_ready_i,
  input wire logic vec_busy_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [sit_pkg::PA_W-1:0] mem_addr_o,
  output logic [63:0] mem_wdata_o,
  output logic [7:0] mem_dest_o,
  input wire logic mem_busy_i,
  input wire logic mem_rvalid_i,
  input wire logic [7:0] mem_rdest_i,
  input wire logic [63:0] mem_rdata_i,
  output logic mem_rready_o,
  input wire logic [sit_pkg::KEY_W-1:0] key_i,
  input wire logic [1:0] pgsz_i,
  output logic st_req_o,
  output logic [sit_pkg::ST_IDX_W-1:0] st_idx_o,
  input wire logic st_rvalid_i,
  input wire logic [sit_pkg::ENT_W-1:0] st_ent0_i,
  input wire logic [sit_pkg::ENT_W-1:0] st_ent1_i,
  output logic acc_int_o
);
  import sit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: stack, register file, result slots
  logic [63:0] stk [STK_WORDS];
  logic [63:0] rf [256];
  logic [72:0] wb [SLOT_N];
  logic [72:0] ss [SLOT_N];
  logic [72:0] next_wb [SLOT_N];
  logic [72:0] next_ss [SLOT_N];
  logic [PC_W-1:0] pc, next_pc;
  logic [PC_W-2:0] fill_w, next_fill_w, base_w, next_base_w;
  logic [PC_W-5:0] next_fetch_addr;
  logic fet_pend, next_fet_pend;
  logic [5:0] stl, next_stl, dv, next_dv;
  logic st2, next_st2;

  // Decode of the instruction at the issue point
  logic [PC_W-2:0] pcw;
  logic [63:0] word;
  logic [31:0] hw;
  logic [3:0] cls;
  logic [2:0] sub;
  logic [7:0] rr, rs, rt;
  logic avail, in_stk, fet_take;
  logic [PC_W-1:0] tgt;
  assign pcw = pc[PC_W-1:1];
  assign word = stk[pcw[5:0]];
  assign hw = pc[0] ? word[31:0] : word[63:32]; // see [RQ2]
  assign cls = hw[30:27];
  assign sub = hw[26:24];
  assign rr = hw[23:16];
  assign rs = hw[15:8];
  assign rt = hw[7:0];
  assign tgt = word[PC_W-1:0];
  assign avail = (pcw < fill_w) && (pcw >= base_w);
  assign in_stk = (tgt[PC_W-1:1] >= base_w) && (tgt[PC_W-1:1] < fill_w);
  assign fet_take = fetch_valid_i && fet_pend && (fetch_addr_o == fill_w[PC_W-2:3]);

  // Operand read with short-stop then write-through bypass
  function automatic logic [63:0] rd(input logic [7:0] a);
    if (ss[0][72] && ss[0][71:64] == a) return ss[0][63:0]; // see [RQ9]
    else if (wb[0][72] && wb[0][71:64] == a) return wb[0][63:0];
    else return rf[a];
  endfunction : rd

  // Integer stand-ins for the unit datapaths; only timing is modelled exactly
  function automatic logic [63:0] alu(input logic [3:0] c, input logic [2:0] s,
                                      input logic [63:0] a, input logic [63:0] b);
    unique case (c)
      C_LOG: return s[0] ? (a ^ b) : (s[1] ? (a | b) : (a & b));
      C_FMUL: return a * b;
      C_FDIV: return (b == 64'h0) ? 64'h0 : a / b;
      C_FSQRT: return a;
      default: return a + b;
    endcase
  endfunction : alu

  logic [63:0] opa, opb;
  assign opa = rd(st2 ? rr : rs); // see [RQ15]
  assign opb = rd(rt);

  ////////////////////////////////////////////////////////////////////////////
  // Issue and fetch
  logic lsq_push, lsq_pst, lsq_room1, lsq_room2, lsq_pend;
  logic [7:0] lsq_preg;
  logic [VA_W-1:0] lsq_pva;
  logic [2:0] lsq_cnt;
  logic ld_wr;
  assign lsq_room1 = lsq_cnt < 3'(LSQ_N);
  assign lsq_room2 = lsq_cnt < 3'(LSQ_N - 1);
  assign ld_wr = mem_rvalid_i && !wb[0][72];
  assign mem_rready_o = !wb[0][72]; // Write bus is shared with unit results

  always_comb begin
    int sl;
    int wl;
    logic go;
    sl = SS_INC;
    wl = WR_INC;
    go = 1'b0;
    next_pc = pc;
    next_stl = (stl != 6'h0) ? stl - 6'h1 : 6'h0;
    next_dv = (dv != 6'h0) ? dv - 6'h1 : 6'h0;
    next_st2 = st2;
    next_fill_w = fill_w;
    next_base_w = base_w;
    next_fet_pend = fet_pend;
    next_fetch_addr = fetch_addr_o;
    vec_valid_o = 1'b0;
    lsq_push = 1'b0;
    lsq_pst = 1'b0;
    lsq_preg = rr;
    lsq_pva = VA_W'(opa + opb);
    for (int k = 0; k < SLOT_N - 1; k++) begin
      next_wb[k] = wb[k + 1];
      next_ss[k] = ss[k + 1];
    end
    next_wb[SLOT_N - 1] = '0;
    next_ss[SLOT_N - 1] = '0;
    unique case (cls)
      C_LOG: begin sl = SS_LOG; wl = WR_LOG; end // see [RQ10]
      C_FADD, C_FMUL: begin sl = SS_FP; wl = WR_FP; end // see [RQ11]
      C_FDIV: begin sl = SS_DIV; wl = WR_DIV; end
      C_FSQRT: begin sl = SS_SQRT; wl = WR_SQRT; end
      default: begin sl = SS_INC; wl = WR_INC; end
    endcase
    // One decision per minor cycle; branch cost counts down first
    if (avail && stl == 6'h0) begin // see [RQ1] [RQ4]
      if (cls == C_VEC) begin
        vec_valid_o = 1'b1; // see [RQ5]
        go = vec_ready_i;
      end else if (cls == C_LOAD) begin
        go = lsq_room1; // see [RQ12]
        lsq_push = go;
      end else if (cls == C_STORE) begin
        // Address entry, then data entry a cycle later
        if (!st2 && lsq_room2) begin // see [RQ12]
          lsq_push = 1'b1;
          lsq_pst = 1'b1;
          next_st2 = 1'b1;
        end else if (st2) begin
          lsq_push = 1'b1;
          lsq_pst = 1'b1;
          lsq_pva = '0;
          next_st2 = 1'b0;
          go = 1'b1;
        end
      end else if (cls == C_BR || cls == C_CALL) begin
        go = 1'b1;
        if (cls == C_CALL && wb[WR_INC - 1][72]) begin
          go = 1'b0;
        end else if (cls == C_CALL || !sub[0] || opa != 64'h0) begin
          if (cls == C_CALL) begin
            next_wb[WR_INC - 1] = {1'b1, rr, 64'(pc + PC_W'(2))};
          end
          next_stl = in_stk ? ((cls == C_CALL) ? CALL_IN : BR_IN) - 6'h1
                            : ((cls == C_CALL) ? CALL_OUT : BR_OUT) - 6'h1; // see [RQ13]
          if (!in_stk) begin
            next_base_w = {tgt[PC_W-1:4], 3'h0};
            next_fill_w = {tgt[PC_W-1:4], 3'h0};
            next_fet_pend = 1'b0;
          end
        end else begin
          next_stl = BR_FALL - 6'h1;
        end
        if (go) next_pc = (cls == C_BR && next_stl == BR_FALL - 6'h1) ? pc + PC_W'(2) : tgt;
        go = 1'b0;
      end else if (!wb[wl - 1][72] && !ss[sl - 1][72] &&
                   !((cls == C_FDIV || cls == C_FSQRT) && dv != 6'h0)) begin // see [RQ14]
        go = 1'b1;
        next_wb[wl - 1] = {1'b1, rr, alu(cls, sub, opa, opb)};
        next_ss[sl - 1] = {1'b1, rr, alu(cls, sub, opa, opb)}; // see [RQ9]
        if (cls == C_FDIV || cls == C_FSQRT) next_dv = 6'(wl - 1);
      end
    end
    if (go) next_pc = hw[31] ? pc + PC_W'(2) : pc + PC_W'(1);
    // Read-ahead: ask for the next sword while sixteen words or fewer remain
    if (fet_take) begin
      next_fill_w = fill_w + (PC_W-1)'(SW_WORDS);
      next_fet_pend = 1'b0;
      if (fill_w - base_w >= (PC_W-1)'(STK_WORDS))
        next_base_w = base_w + (PC_W-1)'(SW_WORDS);
    end else if (!fet_pend && (fill_w - pcw <= (PC_W-1)'(AHEAD)) &&
                 (fill_w - base_w < (PC_W-1)'(STK_WORDS) ||
                  pcw - base_w >= (PC_W-1)'(SW_WORDS))) begin // see [RQ3]
      next_fet_pend = 1'b1;
      next_fetch_addr = next_fill_w[PC_W-2:3];
    end
  end

  assign fetch_req_o = fet_pend;
  assign vec_instr_o = word;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= '0;
      fill_w <= '0;
      base_w <= '0;
      fet_pend <= 1'b0;
      fetch_addr_o <= '0;
      stl <= 6'h0;
      dv <= 6'h0;
      st2 <= 1'b0;
      for (int k = 0; k < SLOT_N; k++) begin
        wb[k] <= '0;
        ss[k] <= '0;
      end
    end else begin
      pc <= next_pc;
      fill_w <= next_fill_w;
      base_w <= next_base_w;
      fet_pend <= next_fet_pend;
      fetch_addr_o <= next_fetch_addr;
      stl <= next_stl;
      dv <= next_dv;
      st2 <= next_st2;
      wb <= next_wb;
      ss <= next_ss;
    end
  end

  // Stack fill and register file writes; arrays need no reset
  always_ff @(posedge clk_i) begin
    if (fet_take) begin
      for (int k = 0; k < SW_WORDS; k++)
        stk[{fill_w[5:3], 3'(k)}] <= fetch_data_i[511 - 64 * k -: 64]; // see [RQ2]
    end
    if (wb[0][72]) rf[wb[0][71:64]] <= wb[0][63:0]; // see [RQ15]
    else if (ld_wr) rf[mem_rdest_i] <= mem_rdata_i; // see [RQ8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Translation: associative registers and space table search
  typedef enum logic [1:0] {SIT_LOOK = 2'b01, SIT_SRCH = 2'b10} sit_xl_e;
  sit_xl_e xl, next_xl;
  logic [ENT_W-1:0] asc [AS_N];
  logic [ENT_W-1:0] next_asc [AS_N];
  logic [ST_IDX_W-1:0] next_st_idx;
  logic [AS_N-1:0] hit;
  logic [3:0] hidx;
  logic [VA_W-1:0] hva;
  logic [2:0] q_hd, q_tl;

  function automatic logic [VA_W-1:0] offm(input logic lg, input logic [1:0] ps);
    int sh;
    sh = lg ? SH_LARGE : (ps == 2'h1) ? SH_2K : (ps == 2'h2) ? SH_8K : SH_512; // see [RQ19]
    return (VA_W'(1) << sh) - VA_W'(1);
  endfunction : offm

  function automatic logic ematch(input logic [ENT_W-1:0] e, input logic [VA_W-1:0] va,
                                  input logic [1:0] ps);
    return e[E_V] && (((e[VA_W-1:0] ^ va) & ~offm(e[E_LG], ps)) == '0); // see [RQ20]
  endfunction : ematch

  // All sixteen compared in the same cycle
  for (genvar i = 0; i < AS_N; i++) begin : g_cmp
    assign hit[i] = ematch(asc[i], hva, pgsz_i); // see [RQ16] [RQ17]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load/store buffer and memory initiation
  logic q_st [LSQ_N];
  logic [7:0] q_rg [LSQ_N];
  logic [VA_W-1:0] q_va [LSQ_N];
  logic [63:0] q_d [LSQ_N];
  logic [2:0] q_hd1, next_hd, next_tl, next_cnt;
  logic sgap, next_sgap, fault, go_mem, found, next_acc;
  logic [ENT_W-1:0] hent, nent;
  logic [PA_W-1:0] pa;
  assign q_hd1 = (q_hd == 3'(LSQ_N - 1)) ? 3'h0 : q_hd + 3'h1;
  assign hva = q_va[q_hd];
  assign hent = asc[hidx];
  assign pa = PA_W'((hent[E_LK-1:E_PB] & ~offm(hent[E_LG], pgsz_i)) |
                    (hva & offm(hent[E_LG], pgsz_i)));
  assign lsq_pend = lsq_cnt != 3'h0;
  assign found = ematch(st_ent0_i, hva, pgsz_i) || ematch(st_ent1_i, hva, pgsz_i);
  assign nent = ematch(st_ent0_i, hva, pgsz_i) ? st_ent0_i : st_ent1_i;

  always_comb begin
    int src;
    logic mv;
    src = AS_N - 1;
    mv = 1'b0;
    hidx = 4'h0;
    for (int k = AS_N - 1; k >= 0; k--) if (hit[k]) hidx = 4'(k);
    next_xl = xl;
    next_st_idx = st_idx_o;
    next_sgap = 1'b0;
    next_acc = 1'b0;
    fault = 1'b0;
    go_mem = 1'b0;
    // Key against lock of the hit page; a cycle between faults keeps each a pulse
    if (xl == SIT_LOOK && lsq_pend && hit != '0 && hent[E_V-2:E_LK] != key_i && !acc_int_o) begin
      fault = 1'b1; // see [RQ21]
    end else if (xl == SIT_LOOK && lsq_pend && hit != '0) begin
      // Memory-referencing work waits for the vector side
      go_mem = !mem_busy_i && !vec_busy_i && !acc_int_o &&
               (q_st[q_hd] ? (!sgap && lsq_cnt >= 3'h2) : mem_rready_o); // see [RQ5] [RQ6]
      next_sgap = go_mem && q_st[q_hd];
      mv = go_mem;
      src = int'(hidx);
    end else if (xl == SIT_LOOK && lsq_pend) begin
      next_xl = SIT_SRCH; // see [RQ23]
      next_st_idx = '0;
    end
    if (xl == SIT_SRCH && st_rvalid_i) begin
      if (found) begin
        mv = 1'b1; // see [RQ23]
        next_xl = SIT_LOOK;
      end else if (st_idx_o == ST_IDX_W'(ST_PAIRS - 1)) begin
        fault = 1'b1; // see [RQ22]
        next_xl = SIT_LOOK;
      end else begin
        next_st_idx = st_idx_o + ST_IDX_W'(1); // see [RQ17]
      end
    end
    next_acc = fault;
    // Used or new entry goes to the top; older ones slide down
    for (int k = 0; k < AS_N; k++) begin
      next_asc[k] = asc[k];
      if (mv && k == 0) next_asc[k] = (xl == SIT_SRCH) ? nent : asc[src]; // see [RQ18]
      else if (mv && k <= src) next_asc[k] = asc[k - 1];
    end
    next_hd = q_hd;
    next_cnt = lsq_cnt;
    if (go_mem || fault) begin
      next_hd = q_st[q_hd] ? ((q_hd1 == 3'(LSQ_N - 1)) ? 3'h0 : q_hd1 + 3'h1) : q_hd1;
      next_cnt = q_st[q_hd] ? lsq_cnt - 3'h2 : lsq_cnt - 3'h1;
    end
    next_tl = q_tl;
    if (lsq_push) begin
      next_tl = (q_tl == 3'(LSQ_N - 1)) ? 3'h0 : q_tl + 3'h1; // see [RQ7]
      next_cnt = next_cnt + 3'h1;
    end
  end

  assign st_req_o = (xl == SIT_SRCH);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xl <= SIT_LOOK;
      st_idx_o <= '0;
      q_hd <= 3'h0;
      q_tl <= 3'h0;
      lsq_cnt <= 3'h0;
      sgap <= 1'b0;
      acc_int_o <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 64'h0;
      mem_dest_o <= 8'h0;
      for (int k = 0; k < AS_N; k++) asc[k] <= '0;
    end else begin
      xl <= next_xl;
      st_idx_o <= next_st_idx;
      q_hd <= next_hd;
      q_tl <= next_tl;
      lsq_cnt <= next_cnt;
      sgap <= next_sgap; // see [RQ6]
      acc_int_o <= next_acc;
      mem_req_o <= go_mem;
      mem_we_o <= go_mem && q_st[q_hd];
      if (go_mem) mem_addr_o <= pa;
      if (go_mem) mem_wdata_o <= q_d[q_hd1];
      if (go_mem) mem_dest_o <= q_rg[q_hd];
      asc <= next_asc;
    end
  end

  // Buffer contents are read only while lsq_cnt is nonzero, so no reset
  always_ff @(posedge clk_i) begin
    if (lsq_push) begin
      q_st[q_tl] <= lsq_pst;
      q_rg[q_tl] <= lsq_preg;
      q_va[q_tl] <= lsq_pva;
      q_d[q_tl] <= opa;
    end
  end
endmodule : sit_core
`default_nettype wire

// >>> sit_core_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checker for the scalar issue and translation core
module sit_core_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fetch_req_o,
  input wire logic [sit_pkg::PC_W-5:0] fetch_addr_o,
  input wire logic fetch_valid_i,
  input wire logic vec_valid_o,
  input wire logic [63:0] vec_instr_o,
  input wire logic vec_ready_i,
  input wire logic vec_busy_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic mem_busy_i,
  input wire logic st_req_o,
  input wire logic [sit_pkg::ST_IDX_W-1:0] st_idx_o,
  input wire logic st_rvalid_i,
  input wire logic acc_int_o
);
  import sit_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Stores take two issue slots, so never two store starts in a row
  a_store_gap_kept: assert property (
    mem_req_o && mem_we_o |=> !(mem_req_o && mem_we_o))
    else $error("store started on two consecutive cycles");
  // Busy memory holds back the next start
  a_mem_busy_stalls: assert property (mem_busy_i |=> !mem_req_o)
    else $error("memory reference started while memory busy");
  // Vector unit on memory means no scalar reference
  a_vec_busy_stalls: assert property (vec_busy_i |=> !mem_req_o)
    else $error("scalar reference started while vector unit busy");
  // Fetch request and address stand until taken
  a_fetch_req_holds: assert property (
    fetch_req_o && !fetch_valid_i |=> fetch_req_o && $stable(fetch_addr_o))
    else $error("fetch request dropped or moved before acceptance");
  // Offered vector instruction stands until the vector unit takes it
  a_vec_offer_holds: assert property (
    vec_valid_o && !vec_ready_i |=> vec_valid_o && $stable(vec_instr_o))
    else $error("vector instruction withdrawn before acceptance");
  // Access interrupt is a single-cycle pulse
  a_int_is_pulse: assert property ($rose(acc_int_o) |=> !acc_int_o)
    else $error("access interrupt longer than one cycle");
  // Faulted cycle starts no reference
  a_int_no_start: assert property (acc_int_o |-> !mem_req_o)
    else $error("reference started in access interrupt cycle");
  // Each answered pair advances the search by one pair
  a_search_steps: assert property (
    st_req_o && st_rvalid_i ##1 st_req_o |-> st_idx_o == $past(st_idx_o) + 12'h001)
    else $error("space table index did not step by one pair");
endmodule : sit_core_chk
`default_nettype wire

// >>> sit_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// Fetch memory, data memory and space table facing the core
module sit_far_model #(
  parameter logic [7:0] LOCK = 8'h5a
) (
  input wire logic clk_i,
  input wire logic f_req_i,
  input wire logic [sit_pkg::PC_W-5:0] f_addr_i,
  output logic f_valid_o,
  output logic [511:0] f_data_o,
  input wire logic m_req_i,
  input wire logic m_we_i,
  input wire logic [7:0] m_dest_i,
  input wire logic m_rready_i,
  output logic m_rvalid_o,
  output logic [7:0] m_rdest_o,
  output logic [63:0] m_rdata_o,
  input wire logic s_req_i,
  output logic s_rvalid_o,
  output logic [sit_pkg::ENT_W-1:0] s_ent0_o,
  output logic [sit_pkg::ENT_W-1:0] s_ent1_o
);
  import sit_pkg::*;
  // Call, load, store, vector, then a load loop
  logic [511:0] sw0 = {64'hc8010000_00000004, 64'h0, 64'h30040101_38010101,
    64'h50000000_00050101, 64'h30060101_00050101, 64'hc0000000_00000008, 128'h0};
  logic [ENT_W-1:0] hit_ent;
  logic [7:0] dq[$];
  int fc = 0;
  int sn = 0;
  assign hit_ent = {1'b1, 1'b0, LOCK, 22'h001000, 48'h0};
  initial begin
    {f_valid_o, f_data_o, m_rvalid_o, m_rdest_o, m_rdata_o} = '0;
    {s_rvalid_o, s_ent0_o, s_ent1_o} = '0;
  end
  ////////////////////////////////////////
  // Sword after three cycles; idle data toggles so stale words never match
  always @(posedge clk_i) begin
    f_valid_o <= 1'b0;
    f_data_o <= ~f_data_o;
    if (f_req_i && !f_valid_o) begin
      fc <= fc + 1;
      if (fc == 2) begin
        f_valid_o <= 1'b1;
        f_data_o <= (f_addr_i == 20'h0) ? sw0 : 512'h0;
        fc <= 0;
      end
    end
  end
  // Load returns in order, held until the write bus takes it
  always @(posedge clk_i) begin
    if (m_req_i && !m_we_i) dq.push_back(m_dest_i);
    if (m_rvalid_o && m_rready_i) begin
      m_rvalid_o <= 1'b0;
      m_rdest_o <= ~m_rdest_o;
      m_rdata_o <= ~m_rdata_o;
    end else if (!m_rvalid_o && dq.size() > 0) begin
      m_rvalid_o <= 1'b1;
      m_rdest_o <= dq.pop_front();
      m_rdata_o <= 64'h0123456789abcdef;
    end
  end
  // Match only in the second entry of the second pair, to force stepping
  always @(posedge clk_i) begin
    s_rvalid_o <= 1'b0;
    s_ent0_o <= ~s_ent0_o;
    s_ent1_o <= ~s_ent1_o;
    if (!s_req_i) begin
      sn <= 0;
    end else if (!s_rvalid_o) begin
      s_rvalid_o <= 1'b1;
      s_ent0_o <= 80'h0;
      s_ent1_o <= (sn == 1) ? hit_ent : 80'h0;
      sn <= sn + 1;
    end
  end
endmodule : sit_far_model
`default_nettype wire

// >>> sit_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sit_core_tb;
  import sit_pkg::*;
  typedef struct {logic we; logic [PA_W-1:0] addr; logic [63:0] wdata;
    logic [7:0] dest;} sit_mreq_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fetch_req_o, fetch_valid_i, vec_valid_o, vec_ready_i, vec_busy_i, mem_req_o, mem_we_o;
  logic mem_busy_i, mem_rvalid_i, mem_rready_o, st_req_o, st_rvalid_i, acc_int_o;
  logic [PC_W-5:0] fetch_addr_o;
  logic [511:0] fetch_data_i;
  logic [63:0] vec_instr_o, mem_wdata_o, mem_rdata_i;
  logic [PA_W-1:0] mem_addr_o;
  logic [7:0] mem_dest_o, mem_rdest_i, key_i;
  logic [1:0] pgsz_i;
  logic [ST_IDX_W-1:0] st_idx_o;
  logic [ENT_W-1:0] st_ent0_i, st_ent1_i;
  sit_mreq_s mq[$];
  int errors = 0;
  int num_checks = 0;
  int base = 0;
  ////////////////////////////////////////
  always #4 clk_i = ~clk_i;
  sit_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .fetch_req_o(fetch_req_o),
    .fetch_addr_o(fetch_addr_o), .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
    .vec_valid_o(vec_valid_o), .vec_instr_o(vec_instr_o), .vec_ready_i(vec_ready_i),
    .vec_busy_i(vec_busy_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_dest_o(mem_dest_o),
    .mem_busy_i(mem_busy_i), .mem_rvalid_i(mem_rvalid_i), .mem_rdest_i(mem_rdest_i),
    .mem_rdata_i(mem_rdata_i), .mem_rready_o(mem_rready_o), .key_i(key_i), .pgsz_i(pgsz_i),
    .st_req_o(st_req_o), .st_idx_o(st_idx_o), .st_rvalid_i(st_rvalid_i),
    .st_ent0_i(st_ent0_i), .st_ent1_i(st_ent1_i), .acc_int_o(acc_int_o));
  sit_far_model far_u (.clk_i(clk_i), .f_req_i(fetch_req_o), .f_addr_i(fetch_addr_o),
    .f_valid_o(fetch_valid_i), .f_data_o(fetch_data_i), .m_req_i(mem_req_o),
    .m_we_i(mem_we_o), .m_dest_i(mem_dest_o), .m_rready_i(mem_rready_o),
    .m_rvalid_o(mem_rvalid_i), .m_rdest_o(mem_rdest_i), .m_rdata_o(mem_rdata_i),
    .s_req_i(st_req_o), .s_rvalid_o(st_rvalid_i), .s_ent0_o(st_ent0_i), .s_ent1_o(st_ent1_i));
  // Log memory starts in order; checks read this, not the live ports
  always @(posedge clk_i) begin
    if (mem_req_o === 1'b1) mq.push_back('{mem_we_o, mem_addr_o, mem_wdata_o, mem_dest_o});
  end
  ////////////////////////////////////////
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_of_test();
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  function automatic bit cond(input int sel);
    case (sel)
      0: return fetch_req_o === 1'b1;
      1: return mq.size() >= 2;
      2: return vec_valid_o === 1'b1;
      3: return acc_int_o === 1'b1;
      4: return mq.size() > base;
      default: return fetch_req_o === 1'b1 && fetch_addr_o === 20'h00001;
    endcase
  endfunction : cond
  // Bounded wait; a hang is a mismatch, not a stuck run
  task wait_for(input int sel);
    int n;
    n = 0;
    while (!cond(sel) && n < 600) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 600) begin
      errors++;
      end_of_test();
    end
  endtask : wait_for
  ////////////////////////////////////////
  task t_reset_quiet();
    check(mem_req_o, 64'h0);
    check(fetch_req_o, 64'h0);
    check(mem_rready_o, 64'h1);
  endtask : t_reset_quiet
  // Sword 0 first, then read-ahead asks for the next sword
  task t_fetch();
    wait_for(0);
    check(fetch_addr_o, 64'h0);
    wait_for(5);
    check(fetch_addr_o, 64'h1);
  endtask : t_fetch
  // Miss, two-pair search, install, then load and store on the mapped page
  task t_memory();
    wait_for(1);
    check(mq[0].we, 64'h0);
    check(mq[0].addr, 64'h1004);
    check(mq[0].dest, 64'h04);
    check(mq[1].we, 64'h1);
    check(mq[1].addr, 64'h1004);
    check(mq[1].wdata, 64'h2);
  endtask : t_memory
  // Offer already stands after the memory test; vector unit stalls five more cycles before taking it
  task t_vector();
    wait_for(2);
    check(vec_instr_o, 64'h50000000_00050101);
    repeat (4) @(posedge clk_i);
    #1;
    check(vec_valid_o, 64'h1);
    @(posedge clk_i) vec_ready_i <= 1'b1;
    @(posedge clk_i) vec_ready_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check(vec_valid_o, 64'h0);
  endtask : t_vector
  // Memory busy, then vector busy, each stops the load loop's memory starts
  task automatic t_busy();
    int n0;
    for (int s = 0; s < 2; s++) begin
      base = mq.size();
      wait_for(4);
      check(mq[mq.size()-1].dest, 64'h06);
      @(posedge clk_i);
      if (s == 0) mem_busy_i <= 1'b1;
      else vec_busy_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      n0 = mq.size();
      // Long enough for the loop to queue a load behind the pause
      repeat (20) @(posedge clk_i);
      #1;
      check(mq.size(), n0);
      @(posedge clk_i);
      mem_busy_i <= 1'b0;
      vec_busy_i <= 1'b0;
      base = mq.size();
      wait_for(4);
    end
  endtask : t_busy
  // Wrong key: one-cycle fault and no reference reaches memory
  task t_lock();
    @(posedge clk_i) key_i <= 8'ha5;
    wait_for(3);
    base = mq.size();
    @(posedge clk_i);
    #1;
    check(acc_int_o, 64'h0);
    repeat (20) @(posedge clk_i);
    #1;
    check(mq.size(), base);
  endtask : t_lock
  initial begin
    vec_ready_i = 1'b0;
    vec_busy_i = 1'b0;
    mem_busy_i = 1'b0;
    key_i = 8'h5a;
    pgsz_i = 2'h0;
    repeat (3) @(posedge clk_i);
    #1;
    t_reset_quiet();
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_fetch();
    t_memory();
    t_vector();
    t_busy();
    t_lock();
    end_of_test();
  end
endmodule : sit_core_tb
bind sit_core sit_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .fetch_req_o(fetch_req_o),
  .fetch_addr_o(fetch_addr_o), .fetch_valid_i(fetch_valid_i), .vec_valid_o(vec_valid_o),
  .vec_instr_o(vec_instr_o), .vec_ready_i(vec_ready_i), .vec_busy_i(vec_busy_i),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_busy_i(mem_busy_i), .st_req_o(st_req_o),
  .st_idx_o(st_idx_o), .st_rvalid_i(st_rvalid_i), .acc_int_o(acc_int_o));
`default_nettype wire
